// ---- design/lm_pkg.sv ----
/*
  shared constants for the interrupt latency meter: register word addresses,
  control field layout, sense encodings and channel states.
  assumes nothing of its surroundings; imported by every design file.
*/
package lm_pkg;
  localparam int LM_MAX_CH = 32;
  localparam int LM_DW = 32;
  localparam int LM_AW = 6;
  localparam int LM_CH_IDX_W = 5;
  // word addresses of the fixed registers above the latency words, and of the last latency word
  localparam logic [LM_AW-1:0] LM_ADDR_CTRL = 6'h20;
  localparam logic [LM_AW-1:0] LM_ADDR_FREQ = 6'h21;
  localparam logic [LM_AW-1:0] LM_ADDR_STOP = 6'h22;
  localparam logic [LM_AW-1:0] LM_ADDR_VALID = 6'h23;
  localparam logic [LM_AW-1:0] LM_ADDR_LAT_LAST = 6'h1f;
  // control word layout
  localparam int LM_CTRL_EN_BIT = 0;
  localparam int LM_CTRL_SENSE_BIT = 1;
  localparam int LM_CTRL_CNT_LSB = 2;
  localparam int LM_CTRL_CNT_W = 6;
  localparam int LM_CTRL_VER_LSB = 8;
  localparam int LM_CTRL_VER_W = 24;
  // irq_sense_select encodings
  localparam logic LM_SENSE_LEVEL = 1'b0;
  localparam logic LM_SENSE_PULSE = 1'b1;
  localparam logic [LM_DW-1:0] LM_ZERO_WORD = 32'h0000_0000;
  localparam logic [LM_DW-1:0] LM_COUNT_STEP = 32'h0000_0001;
  typedef enum logic [1:0] {LM_IDLE, LM_RUN, LM_STOP, LM_STORE} lm_state_e;
endpackage : lm_pkg

// ---- design/lm_chan_if.sv ----
/*
  carrier of per-channel results from the channel array to the bus slave.
  assumes one clock domain; the top drives, the slave reads and clears.
*/
`timescale 1ns/1ps
interface lm_chan_if;
  import lm_pkg::*;
  logic [LM_DW-1:0] latency [LM_MAX_CH];
  logic [LM_MAX_CH-1:0] valid;
  logic [LM_MAX_CH-1:0] valid_clear;
  modport chan (output latency, output valid, input valid_clear);
  modport slave (input latency, input valid, output valid_clear);
endinterface : lm_chan_if

// ---- design/lm_edge_detect.sv ----
/*
  interrupt detector for one channel: start and end strobes from one irq line in level mode; in pulse mode start is the line itself and end stays low.
  assumes irq_i is synchronous to ref_clk_i.
*/
`timescale 1ns/1ps
module lm_edge_detect #(
  parameter logic irq_sense_select = lm_pkg::LM_SENSE_LEVEL
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic irq_i,
  output logic start_o,
  output logic end_o
);
  import lm_pkg::*;
  logic irq_d;
  logic toggle;

  // one-cycle delay of the line
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_d <= 1'b0;
    end else begin
      irq_d <= irq_i;
    end
  end

  // xor of delayed and live line; polarity splits it into start and end
  assign toggle = irq_i ^ irq_d;
  always_comb begin
    if (irq_sense_select == LM_SENSE_PULSE) begin
      start_o = irq_i;
      end_o = 1'b0;
    end else begin
      start_o = toggle & irq_i;
      end_o = toggle & irq_d;
    end
  end
endmodule : lm_edge_detect

// ---- design/lm_slave.sv ----
/*
  memory-mapped slave with waitrequest: address decode, registered read data,
  completion only when the addressed data is ready.
  assumes the master holds read or write until it sees waitrequest low.
*/
`timescale 1ns/1ps
module lm_slave #(
  parameter int channel_count = lm_pkg::LM_MAX_CH
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [lm_pkg::LM_AW-1:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [lm_pkg::LM_DW-1:0] ctrl_word_i,
  input wire logic [lm_pkg::LM_DW-1:0] freq_word_i,
  input wire logic [lm_pkg::LM_DW-1:0] stop_word_i,
  lm_chan_if.slave chan,
  output logic accept_o,
  output logic [lm_pkg::LM_DW-1:0] readdata_o,
  output logic waitrequest_o
);
  import lm_pkg::*;
  logic is_lat;
  logic lat_cfg;
  logic ready;
  logic [LM_CH_IDX_W-1:0] idx;
  logic [LM_DW-1:0] next_readdata;

  assign idx = address_i[LM_CH_IDX_W-1:0];
  assign is_lat = (address_i <= LM_ADDR_LAT_LAST);
  assign lat_cfg = is_lat && (32'(idx) < channel_count);

  // a configured latency word is ready only once its valid flag is set
  always_comb begin
    if (lat_cfg) begin
      ready = chan.valid[idx];
    end else begin
      ready = 1'b1;
    end
  end

  // read decode; unmapped and unconfigured words read as zero
  always_comb begin
    if (lat_cfg) begin
      next_readdata = chan.latency[idx];
    end else if (is_lat) begin
      next_readdata = LM_ZERO_WORD;
    end else if (address_i == LM_ADDR_CTRL) begin
      next_readdata = ctrl_word_i;
    end else if (address_i == LM_ADDR_FREQ) begin
      next_readdata = freq_word_i;
    end else if (address_i == LM_ADDR_STOP) begin
      next_readdata = stop_word_i;
    end else if (address_i == LM_ADDR_VALID) begin
      next_readdata = chan.valid;
    end else begin
      next_readdata = LM_ZERO_WORD;
    end
  end

  // the transfer completes in the cycle waitrequest is low
  assign accept_o = (read_i || write_i) && !waitrequest_o;

  // waitrequest sits high and drops for one cycle per completed transfer
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      waitrequest_o <= 1'b1;
    end else begin
      waitrequest_o <= !((read_i || write_i) && ready && waitrequest_o);
    end
  end

  // read data registered alongside the waitrequest drop: zero fixed latency
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      readdata_o <= LM_ZERO_WORD;
    end else if (read_i && ready && waitrequest_o) begin
      readdata_o <= next_readdata;
    end
  end

  // a consumed latency read clears that channel's valid flag
  always_comb begin
    chan.valid_clear = '0;
    if (read_i && lat_cfg && !waitrequest_o) begin
      chan.valid_clear[idx] = 1'b1;
    end
  end
endmodule : lm_slave

// ---- design/lm_latency_meter.sv ----
/*
  latency_meter top: per-channel interrupt latency counters, control and
  counter-stop registers, and the waitrequest slave port.
  assumes irq lines and reset release are synchronous to ref_clk_i.
*/
// Design decisions made here: the placing of the registers and strobed register access.
`timescale 1ns/1ps
module lm_latency_meter #(
  parameter logic [32:0] clock_freq_hz = 33'h0_0000_0000,
  parameter logic irq_sense_select = lm_pkg::LM_SENSE_LEVEL,
  parameter int channel_count = lm_pkg::LM_MAX_CH,
  parameter logic [lm_pkg::LM_CTRL_VER_W-1:0] version = 24'h000001 // arbitrary value
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [lm_pkg::LM_MAX_CH-1:0] irq_i,
  input wire logic [lm_pkg::LM_AW-1:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [lm_pkg::LM_DW-1:0] writedata_i,
  output logic [lm_pkg::LM_DW-1:0] readdata_o,
  output logic waitrequest_o
);
  import lm_pkg::*;
  lm_chan_if chan ();
  logic global_enable;
  logic [LM_DW-1:0] stop_bits;
  logic [LM_DW-1:0] ctrl_word;
  logic [LM_DW-1:0] freq_word;
  logic accept;

  // control word: version, channel count, sense, enable
  assign ctrl_word = {version, LM_CTRL_CNT_W'(channel_count), irq_sense_select, global_enable};
  assign freq_word = clock_freq_hz[LM_DW-1:0];

  // global enable: the only writable control bit
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      global_enable <= 1'b0;
    end else if (accept && write_i && address_i == LM_ADDR_CTRL) begin
      global_enable <= writedata_i[LM_CTRL_EN_BIT];
    end
  end

  // stop bits; every write outside the configured latency words takes two cycles so stop writes are spaced apart
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      stop_bits <= LM_ZERO_WORD;
    end else if (accept && write_i && address_i == LM_ADDR_STOP) begin
      stop_bits <= writedata_i;
    end
  end

  // one counter channel per configured irq line; the rest report nothing
  for (genvar c = 0; c < LM_MAX_CH; c++) begin : g_ch
    if (c < channel_count) begin : g_on
      lm_state_e state;
      logic [LM_DW-1:0] count;
      logic start;
      logic stop_evt;
      logic halt;

      lm_edge_detect #(
        .irq_sense_select(irq_sense_select)
      ) u_det (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .irq_i(irq_i[c]),
        .start_o(start),
        .end_o(stop_evt)
      );

      // level mode ends on the falling pulse and ignores stop bits
      assign halt = (irq_sense_select == LM_SENSE_PULSE) ? stop_bits[c] : stop_evt;

      // idle, run (enable set), stop, store: data ready three cycles on
      always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
          state <= LM_IDLE;
        end else begin
          case (state)
            LM_IDLE: begin
              // a pulse-mode start waits for a cleared stop bit
              if (start && global_enable &&
                  !(irq_sense_select == LM_SENSE_PULSE && stop_bits[c])) begin
                state <= LM_RUN;
              end
            end
            LM_RUN: begin
              if (halt) begin
                state <= LM_STOP;
              end
            end
            LM_STOP: begin
              state <= LM_STORE;
            end
            default: begin
              state <= LM_IDLE;
            end
          endcase
        end
      end

      // counter: cleared at start, counts while running, re-armed by a
      // new level edge; later pulses in pulse mode leave it alone
      always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
          count <= LM_ZERO_WORD;
        end else if (state == LM_IDLE && start) begin
          count <= LM_ZERO_WORD;
        end else if (state == LM_RUN && start && irq_sense_select == LM_SENSE_LEVEL) begin
          count <= LM_ZERO_WORD;
        end else if (state == LM_RUN) begin
          count <= count + LM_COUNT_STEP;
        end
      end

      // copy into the latency word in the store state
      always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
          chan.latency[c] <= LM_ZERO_WORD;
        end else if (state == LM_STORE) begin
          chan.latency[c] <= count;
        end
      end

      // valid flag: store wins over a clearing read in the same cycle
      always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
          chan.valid[c] <= 1'b0;
        end else if (state == LM_STORE) begin
          chan.valid[c] <= 1'b1;
        end else if (chan.valid_clear[c]) begin
          chan.valid[c] <= 1'b0;
        end
      end
    end else begin : g_off
      assign chan.latency[c] = LM_ZERO_WORD;
      assign chan.valid[c] = 1'b0;
    end
  end

  lm_slave #(
    .channel_count(channel_count)
  ) u_slave (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .address_i(address_i),
    .read_i(read_i),
    .write_i(write_i),
    .ctrl_word_i(ctrl_word),
    .freq_word_i(freq_word),
    .stop_word_i(stop_bits),
    .chan(chan.slave),
    .accept_o(accept),
    .readdata_o(readdata_o),
    .waitrequest_o(waitrequest_o)
  );
endmodule : lm_latency_meter

// ---- testbench/lm_latency_meter_sva.sv ----
/*
  port checker for the latency meter: bus handshake and fixed read values.
  assumes one clock and the level of rst_i as reset.
*/
`timescale 1ns/1ps
module lm_latency_meter_sva
  import lm_pkg::*;
#(
  parameter logic [32:0] clock_freq_hz = 33'h0_0000_0000,
  parameter logic irq_sense_select = 1'b0,
  parameter int channel_count = 32
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [31:0] irq_i,
  input wire logic [5:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [31:0] writedata_i,
  input wire logic [31:0] readdata_o,
  input wire logic waitrequest_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  logic ever_irq;
  // configured latency reads may only complete once some line has fired
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) ever_irq <= 1'b0;
    else if (|irq_i) ever_irq <= 1'b1;
  end
  sequence s_rd_done(logic [5:0] a);
    read_i && !waitrequest_o && address_i == a;
  endsequence
  sequence s_unconf_done;
    read_i && !waitrequest_o && address_i <= LM_ADDR_LAT_LAST
      && int'(address_i) >= channel_count;
  endsequence
  chk_wait_idle: assert property (!read_i && !write_i |=> waitrequest_o)
    else $error("waitrequest low without a transfer");
  chk_wait_pulse: assert property (!waitrequest_o |=> waitrequest_o)
    else $error("waitrequest low longer than one cycle");
  chk_wait_cause: assert property ($fell(waitrequest_o) |-> $past(read_i || write_i))
    else $error("waitrequest fell with no request");
  chk_write_done: assert property (write_i && waitrequest_o |=> !waitrequest_o)
    else $error("write not completed next cycle");
  chk_early_stall: assert property (!ever_irq && read_i && int'(address_i) < channel_count
    |=> waitrequest_o)
    else $error("latency read completed before any interrupt");
  chk_unconf_zero: assert property (s_unconf_done |-> readdata_o == LM_ZERO_WORD)
    else $error("unconfigured latency word not zero");
  chk_freq_value: assert property (s_rd_done(LM_ADDR_FREQ) |-> readdata_o == clock_freq_hz[31:0])
    else $error("frequency word wrong");
  chk_ctrl_fields: assert property (s_rd_done(LM_ADDR_CTRL) |->
    readdata_o[7:2] == 6'(channel_count) && readdata_o[1] == irq_sense_select)
    else $error("control fields wrong");
endmodule : lm_latency_meter_sva
bind lm_latency_meter lm_latency_meter_sva #(.clock_freq_hz(clock_freq_hz),
  .irq_sense_select(irq_sense_select), .channel_count(channel_count)) u_sva (
  .ref_clk_i(ref_clk_i), .rst_i(rst_i), .irq_i(irq_i), .address_i(address_i),
  .read_i(read_i), .write_i(write_i), .writedata_i(writedata_i),
  .readdata_o(readdata_o), .waitrequest_o(waitrequest_o));

// ---- testbench/lm_host_model.sv ----
/*
  processor model: raises irq lines and runs bus transfers.
  assumes the slave answers with waitrequest low for one cycle.
*/
`timescale 1ns/1ps
module lm_host_model (
  input wire logic ref_clk_i,
  input wire logic waitrequest_i,
  input wire logic [31:0] readdata_i,
  output logic [31:0] irq_o,
  output logic [5:0] address_o,
  output logic read_o,
  output logic write_o,
  output logic [31:0] writedata_o
);
  initial begin
    irq_o = 32'h0;
    address_o = 6'h00;
    read_o = 1'b0;
    write_o = 1'b0;
    writedata_o = 32'h0;
  end
  // request held until the edge that sees waitrequest low, then a free cycle
  task automatic xfer(input logic wr, input logic [5:0] a, input logic [31:0] wd,
                      output logic [31:0] d, output int n);
    n = 0;
    address_o <= a;
    writedata_o <= wd;
    read_o <= !wr;
    write_o <= wr;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (waitrequest_i !== 1'b0 && n < 2000);
    d = readdata_i;
    read_o <= 1'b0;
    write_o <= 1'b0;
    address_o <= ~a; // released lines do not keep the old value
    @(posedge ref_clk_i);
  endtask : xfer
  // irq changes only just after a clock edge; a mask lets lines rise together
  task automatic fire(input logic [31:0] m, input int len);
    irq_o <= irq_o | m;
    repeat (len) @(posedge ref_clk_i);
    irq_o <= irq_o & ~m;
  endtask : fire
endmodule : lm_host_model

// ---- testbench/tb_top.sv ----
/*
  self-checking bench: a level-mode meter with four channels and a pulse-mode
  meter with all channels, 250 MHz clock.
  assumes one host model per meter for all bus and irq traffic.
*/
`timescale 1ns/1ps
module tb_top;
  import lm_pkg::*;
  logic ref_clk, rst, rd, wr, wreq;
  logic [31:0] irq, wdata, rdata, d;
  logic [5:0] addr;
  logic rd_p, wr_p, wreq_p;
  logic [31:0] irq_p, wdata_p, rdata_p, d2;
  logic [5:0] addr_p;
  int mismatches = 0;
  int checks_done = 0;
  int cycles = 0;
  int n;
  // version values are arbitrary
  lm_latency_meter #(.clock_freq_hz(33'h0_0ee6_b280), .irq_sense_select(LM_SENSE_LEVEL),
    .channel_count(4), .version(24'h00_0001)) DUT (.ref_clk_i(ref_clk), .rst_i(rst),
    .irq_i(irq),
    .address_i(addr), .read_i(rd), .write_i(wr), .writedata_i(wdata),
    .readdata_o(rdata), .waitrequest_o(wreq));
  lm_host_model host (.ref_clk_i(ref_clk), .waitrequest_i(wreq), .readdata_i(rdata),
    .irq_o(irq), .address_o(addr), .read_o(rd), .write_o(wr), .writedata_o(wdata));
  // pulse-mode meter with the default channel count and its own host
  lm_latency_meter #(.clock_freq_hz(33'h0_0ee6_b280), .irq_sense_select(LM_SENSE_PULSE),
    .channel_count(32), .version(24'h00_0001)) DUT_P (.ref_clk_i(ref_clk), .rst_i(rst),
    .irq_i(irq_p), .address_i(addr_p), .read_i(rd_p), .write_i(wr_p),
    .writedata_i(wdata_p), .readdata_o(rdata_p), .waitrequest_o(wreq_p));
  lm_host_model host_p (.ref_clk_i(ref_clk), .waitrequest_i(wreq_p), .readdata_i(rdata_p),
    .irq_o(irq_p), .address_o(addr_p), .read_o(rd_p), .write_o(wr_p),
    .writedata_o(wdata_p));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : close_out
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  // hang guard: the whole run needs under two hundred cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      close_out();
    end
  end
  initial begin
    rst = 1'b1;
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    check({31'h0, wreq}, 32'h1);
    host.xfer(1'b1, LM_ADDR_FREQ, 32'hffff_ffff, d, n); // read-only, ignored
    host.xfer(1'b0, LM_ADDR_FREQ, 32'h0, d, n);
    check(d, 32'h0ee6_b280);
    host.xfer(1'b1, LM_ADDR_CTRL, 32'h0000_0001, d, n);
    host.xfer(1'b0, LM_ADDR_CTRL, 32'h0, d, n);
    check(d, 32'h0000_0111);
    host.xfer(1'b0, 6'h05, 32'h0, d, n);
    check(d, LM_ZERO_WORD);
    host.xfer(1'b0, 6'h30, 32'h0, d, n);
    check(d, LM_ZERO_WORD);
    $display("test registers done");
    // latency read before any interrupt must stall until one is stored
    fork
      host.xfer(1'b0, 6'h01, 32'h0, d, n);
      begin
        repeat (20) @(posedge ref_clk);
        host.fire(32'h2, 3);
      end
    join
    check(32'(n > 22), 32'h1);
    check(d, 32'h3);
    $display("test stall done");
    // long run then short run: the short one proves the count restarts
    for (int i = 0; i < 2; i++) begin
      host.fire(32'h1, (i == 0) ? 9 : 3);
      repeat (4) @(posedge ref_clk);
      host.xfer(1'b0, LM_ADDR_VALID, 32'h0, d, n);
      check(d, 32'h1);
      host.xfer(1'b0, 6'h00, 32'h0, d, n);
      check(d, (i == 0) ? 32'h9 : 32'h3);
      check(32'(n), 32'h2);
      host.xfer(1'b0, LM_ADDR_VALID, 32'h0, d, n);
      check(d, 32'h0);
    end
    $display("test level done");
    // pulse mode: a second pulse must not restart the count; the stop write
    // halts it and the stored value is one cycle above the true latency
    host_p.xfer(1'b1, LM_ADDR_CTRL, 32'h0000_0001, d, n);
    host_p.xfer(1'b0, LM_ADDR_CTRL, 32'h0, d, n);
    check(d, 32'h0000_0183);
    host_p.fire(32'h4, 1);
    repeat (2) @(posedge ref_clk);
    host_p.fire(32'h4, 1);
    repeat (2) @(posedge ref_clk);
    host_p.xfer(1'b1, LM_ADDR_STOP, 32'h0000_0004, d, n);
    host_p.xfer(1'b0, 6'h02, 32'h0, d, n);
    check(d, 32'h8);
    // stop bit still set: a new pulse must not start a run
    host_p.fire(32'h4, 1);
    repeat (6) @(posedge ref_clk);
    host_p.xfer(1'b0, LM_ADDR_VALID, 32'h0, d, n);
    check(d, 32'h0);
    // clear, start two lines together, halt them with back-to-back writes
    host_p.xfer(1'b1, LM_ADDR_STOP, 32'h0, d, n);
    host_p.fire(32'hc, 1);
    host_p.xfer(1'b1, LM_ADDR_STOP, 32'h0000_0004, d, n);
    host_p.xfer(1'b1, LM_ADDR_STOP, 32'h0000_000c, d, n);
    host_p.xfer(1'b0, 6'h02, 32'h0, d, n);
    check(d, 32'h3);
    host_p.xfer(1'b0, 6'h03, 32'h0, d2, n);
    check(d2, 32'h6);
    check(32'(d2 - d >= 32'h2), 32'h1);
    $display("test pulse done");
    close_out();
  end
endmodule : tb_top
